// >>> logic/clock_loss_monitor_irq_pin.sv
`timescale 1ns/1ps
// Overview of operation
// - Reload bit set restores memory defaults on restart after fault shutdown.
// - Monitor A watches serial audio clock (0) or density port clock (1).
// - Monitor B watches playback, sense or PLL clock; code 3 reserved.
// - Monitor A works only while its enable bit is one.
// - Monitor B works only while its enable bit is one.
// - Enabled monitor seeing no clock for its timeout shuts the chip down.
// - Three-bit timeout codes select 11 ms up to 1.2 s.
// - Timeout register resets to 3Fh, longest time for both monitors.
// - Drive field picks push-pull, one-sided open drain, or pulled styles.
// - In general-purpose mode the pin shows the output value bit.
// - Mode field picks off, interrupt, general-purpose or divider clock output.
// - Pin setup register resets to 21h.
// - Shape field gives single 2 ms pulse, 2/4 ms train, or held level.
// - Sticky flags record events since last read and clear on read.
// - Mask bits choose which clock errors can raise the interrupt.
module clock_loss_monitor_irq_pin
    import clk_mon_pkg::*;
#(
    parameter int MS_CYCLES = MS_NS / CLK_PERIOD_NS,
    parameter int PULSE_CYCLES = PULSE_MS * MS_CYCLES,
    parameter int PERIOD_CYCLES = PERIOD_MS * MS_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic serial_audio_clock_in,
    input wire logic density_port_clock_in,
    input wire logic playback_mod_clock_in,
    input wire logic sense_mod_clock_in,
    input wire logic pll_clock_in,
    input wire logic density_input_divider_clock_in,
    output logic shutdown_out,
    output logic restore_defaults_out,
    output logic alert_pin_out,
    output logic alert_pin_oe_n_out,
    output logic alert_pull_up_out,
    output logic alert_pull_down_out,
    output logic alert_buffer_on_out
);
    logic [7:0] err_reload_ctrl;
    logic [7:0] window_time;
    logic [7:0] pin_setup;
    logic [7:0] shape_setup;
    logic [7:0] mask;
    logic [7:0] sticky;
    logic clk_err_status;
    logic [31:0] ms_prescale;
    logic ms_tick;
    logic level_a;
    logic level_b;
    logic b_src_ok;
    logic loss_a;
    logic loss_b;
    logic raise;
    logic pending;
    logic sticky_read;
    shape_state_t state;
    shape_state_t next_state;
    logic [31:0] shape_count;
    logic irq_level;
    logic pin_value;
    logic next_oe_n;
    logic [2:0] drive;
    logic [2:0] mode;
    logic [1:0] shape;

    assign drive = pin_setup[BIT_DRIVE_HI:BIT_DRIVE_LO];
    assign mode = pin_setup[BIT_MODE_HI:BIT_MODE_LO];
    assign shape = shape_setup[BIT_SHAPE_HI:BIT_SHAPE_LO];
    assign sticky_read = reg_rd_in && reg_addr_in == ADDR_STICKY;

    // Register writes
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_reload_ctrl <= RST_ERR_RELOAD_CTRL;
            window_time <= RST_WINDOW_TIME;
            pin_setup <= RST_PIN_SETUP;
            shape_setup <= RST_SHAPE_SETUP;
            mask <= RST_ZERO;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_ERR_RELOAD_CTRL: err_reload_ctrl <= reg_wdata_in;
                ADDR_WINDOW_TIME: window_time <= reg_wdata_in;
                ADDR_PIN_SETUP: pin_setup <= reg_wdata_in;
                ADDR_SHAPE_SETUP: shape_setup <= reg_wdata_in;
                ADDR_MASK: mask <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= RST_ZERO;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_CLK_ERR_STATUS: reg_rdata_out <= {7'h00, clk_err_status};
                ADDR_ERR_RELOAD_CTRL: reg_rdata_out <= err_reload_ctrl;
                ADDR_WINDOW_TIME: reg_rdata_out <= window_time;
                ADDR_PIN_SETUP: reg_rdata_out <= pin_setup;
                ADDR_SHAPE_SETUP: reg_rdata_out <= shape_setup;
                ADDR_MASK: reg_rdata_out <= mask;
                ADDR_STICKY: reg_rdata_out <= sticky;
                default: reg_rdata_out <= RST_ZERO;
            endcase
        end
    end

    // Millisecond time base for the detectors
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ms_prescale <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= ms_prescale == 32'(MS_CYCLES - 1);
            ms_prescale <= (ms_prescale == 32'(MS_CYCLES - 1)) ? '0 : ms_prescale + 1'b1;
        end
    end

    assign level_a = err_reload_ctrl[BIT_A_SRC] ? density_port_clock_in
                                                : serial_audio_clock_in;
    always_comb begin
        b_src_ok = 1'b1;
        case (err_reload_ctrl[BIT_B_SRC_HI:BIT_B_SRC_LO])
            SRC_B_PLAYBACK: level_b = playback_mod_clock_in;
            SRC_B_SENSE: level_b = sense_mod_clock_in;
            SRC_B_PLL: level_b = pll_clock_in;
            default: begin
                level_b = 1'b0;
                b_src_ok = 1'b0;
            end
        endcase
    end

    clock_loss_detector monitor_a (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .enable_in(err_reload_ctrl[BIT_A_EN]),
        .clock_level_in(level_a),
        .ms_tick_in(ms_tick),
        .limit_ms_in(TIMEOUT_MS[window_time[BIT_A_TIME_HI:BIT_A_TIME_LO]]),
        .loss_out(loss_a)
    );

    clock_loss_detector monitor_b (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .enable_in(err_reload_ctrl[BIT_B_EN] && b_src_ok),
        .clock_level_in(level_b),
        .ms_tick_in(ms_tick),
        .limit_ms_in(TIMEOUT_MS[window_time[BIT_B_TIME_HI:BIT_B_TIME_LO]]),
        .loss_out(loss_b)
    );

    // Clock error status; a new loss wins over the host clearing it
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_err_status <= 1'b0;
        end else if (loss_a || loss_b) begin
            clk_err_status <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == ADDR_CLK_ERR_STATUS) begin
            clk_err_status <= reg_wdata_in[BIT_ERR_STATUS];
        end
    end

    // Restart happens when the error status drops
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shutdown_out <= 1'b0;
            restore_defaults_out <= 1'b0;
        end else begin
            shutdown_out <= clk_err_status;
            restore_defaults_out <= shutdown_out && !clk_err_status
                                    && err_reload_ctrl[BIT_RELOAD];
        end
    end

    // Sticky flags cleared by reading; a same-cycle event survives
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sticky <= RST_ZERO;
        end else begin
            if (sticky_read) begin
                sticky <= RST_ZERO;
            end
            if (loss_a) begin
                sticky[BIT_A_FLAG] <= 1'b1;
            end
            if (loss_b) begin
                sticky[BIT_B_FLAG] <= 1'b1;
            end
        end
    end

    assign raise = (loss_a && mask[BIT_A_MASK]) || (loss_b && mask[BIT_B_MASK]);
    assign pending = (sticky[BIT_A_FLAG] && mask[BIT_A_MASK])
                     || (sticky[BIT_B_FLAG] && mask[BIT_B_MASK]);

    always_comb begin
        next_state = state;
        case (state)
            SHAPE_IDLE: begin
                if (raise && shape == SHAPE_ONE_PULSE) begin
                    next_state = SHAPE_SINGLE;
                end else if (raise && shape == SHAPE_PULSE_TRAIN) begin
                    next_state = SHAPE_TRAIN;
                end
            end
            SHAPE_SINGLE: begin
                if (shape_count == 32'(PULSE_CYCLES - 1)) begin
                    next_state = SHAPE_IDLE;
                end
            end
            SHAPE_TRAIN: begin
                if (!pending) begin
                    next_state = SHAPE_IDLE;
                end
            end
            default: next_state = SHAPE_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= SHAPE_IDLE;
            shape_count <= '0;
        end else begin
            state <= next_state;
            if (next_state != state || state == SHAPE_IDLE) begin
                shape_count <= '0;
            end else if (state == SHAPE_TRAIN && shape_count == 32'(PERIOD_CYCLES - 1)) begin
                shape_count <= '0;
            end else begin
                shape_count <= shape_count + 1'b1;
            end
        end
    end

    assign irq_level = state == SHAPE_SINGLE
                       || (state == SHAPE_TRAIN && shape_count < 32'(PULSE_CYCLES))
                       || (shape == SHAPE_LEVEL && pending);

    always_comb begin
        case (mode)
            MODE_IRQ: pin_value = irq_level;
            MODE_GPO: pin_value = pin_setup[BIT_GPO_VAL];
            MODE_DIV_CLK: pin_value = density_input_divider_clock_in;
            default: pin_value = 1'b0;
        endcase
        case (drive)
            DRV_PUSH_PULL: next_oe_n = 1'b0;
            DRV_LOW_ONLY: next_oe_n = pin_value;
            DRV_HIGH_ONLY: next_oe_n = !pin_value;
            DRV_LOW_PULLUP: next_oe_n = pin_value;
            DRV_HIGH_PULLDOWN: next_oe_n = !pin_value;
            default: next_oe_n = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alert_pin_out <= 1'b0;
            alert_pin_oe_n_out <= 1'b1;
            alert_pull_up_out <= 1'b0;
            alert_pull_down_out <= 1'b0;
            alert_buffer_on_out <= 1'b0;
        end else begin
            alert_pin_out <= pin_value;
            alert_buffer_on_out <= mode != MODE_OFF;
            alert_pin_oe_n_out <= (mode == MODE_OFF) ? 1'b1 : next_oe_n;
            alert_pull_up_out <= mode != MODE_OFF && drive == DRV_LOW_PULLUP;
            alert_pull_down_out <= mode != MODE_OFF && drive == DRV_HIGH_PULLDOWN;
        end
    end

    AST_LOSS_SETS_STATUS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (loss_a || loss_b) |=> clk_err_status ##1 shutdown_out)
        else $error("clock loss did not shut down");
    AST_STICKY_SURVIVES_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        loss_a && sticky_read |=> sticky[BIT_A_FLAG])
        else $error("monitor A flag lost on read");
    AST_READ_CLEARS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        sticky_read && !loss_a && !loss_b |=> sticky == RST_ZERO)
        else $error("sticky read did not clear flags");
    AST_MASKED_OFF_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state == SHAPE_IDLE && (loss_a || loss_b) && mask == RST_ZERO |=> state == SHAPE_IDLE)
        else $error("masked source started interrupt");
    AST_SINGLE_WIDTH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state == SHAPE_SINGLE |-> shape_count < 32'(PULSE_CYCLES))
        else $error("single pulse too long");
    AST_IRQ_PIN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        mode == MODE_IRQ && state == SHAPE_IDLE && raise && shape == SHAPE_ONE_PULSE
        |=> ##1 alert_pin_out)
        else $error("interrupt pin did not rise");
    AST_GPO_LEVEL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        mode == MODE_GPO && drive == DRV_PUSH_PULL
        |=> alert_pin_out == $past(pin_setup[BIT_GPO_VAL]) && !alert_pin_oe_n_out)
        else $error("general-purpose level wrong");
    AST_OFF_FLOATS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        mode == MODE_OFF |=> alert_pin_oe_n_out && !alert_buffer_on_out)
        else $error("disabled pin still driven");
    AST_OPEN_DRAIN_LOW: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        mode != MODE_OFF && drive == DRV_LOW_ONLY |=> alert_pin_oe_n_out == alert_pin_out)
        else $error("open-drain drove high");
    AST_RELOAD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $fell(clk_err_status) && err_reload_ctrl[BIT_RELOAD] |=> restore_defaults_out)
        else $error("no memory reload on restart");

    COV_SINGLE: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state == SHAPE_SINGLE ##1 state == SHAPE_IDLE);
    COV_TRAIN: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state == SHAPE_TRAIN ##1 state == SHAPE_IDLE);
    COV_RESTART: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        restore_defaults_out);
endmodule

// >>> common/clk_mon_pkg.sv
package clk_mon_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CLK_ERR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_ERR_RELOAD_CTRL = 8'h21;
    localparam logic [7:0] ADDR_WINDOW_TIME = 8'h22;
    localparam logic [7:0] ADDR_PIN_SETUP = 8'h23;
    localparam logic [7:0] ADDR_SHAPE_SETUP = 8'h24;
    localparam logic [7:0] ADDR_MASK = 8'h25;
    localparam logic [7:0] ADDR_STICKY = 8'h26;
    // Reset values
    localparam logic [7:0] RST_ERR_RELOAD_CTRL = 8'h03;
    localparam logic [7:0] RST_WINDOW_TIME = 8'h3f;
    localparam logic [7:0] RST_PIN_SETUP = 8'h21;
    localparam logic [7:0] RST_SHAPE_SETUP = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Field positions
    localparam int BIT_RELOAD = 7;
    localparam int BIT_A_SRC = 4;
    localparam int BIT_B_SRC_HI = 3;
    localparam int BIT_B_SRC_LO = 2;
    localparam int BIT_A_EN = 1;
    localparam int BIT_B_EN = 0;
    localparam int BIT_A_TIME_HI = 5;
    localparam int BIT_A_TIME_LO = 3;
    localparam int BIT_B_TIME_HI = 2;
    localparam int BIT_B_TIME_LO = 0;
    localparam int BIT_DRIVE_HI = 7;
    localparam int BIT_DRIVE_LO = 5;
    localparam int BIT_GPO_VAL = 4;
    localparam int BIT_MODE_HI = 2;
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_SHAPE_HI = 7;
    localparam int BIT_SHAPE_LO = 6;
    localparam int BIT_A_FLAG = 5;
    localparam int BIT_B_FLAG = 2;
    localparam int BIT_A_MASK = 2;
    localparam int BIT_B_MASK = 5;
    localparam int BIT_ERR_STATUS = 0;
    // Encodings
    localparam logic [1:0] SRC_B_PLAYBACK = 2'h0;
    localparam logic [1:0] SRC_B_SENSE = 2'h1;
    localparam logic [1:0] SRC_B_PLL = 2'h2;
    localparam logic [2:0] DRV_PUSH_PULL = 3'h0;
    localparam logic [2:0] DRV_LOW_ONLY = 3'h1;
    localparam logic [2:0] DRV_HIGH_ONLY = 3'h2;
    localparam logic [2:0] DRV_LOW_PULLUP = 3'h3;
    localparam logic [2:0] DRV_HIGH_PULLDOWN = 3'h4;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_IRQ = 3'h1;
    localparam logic [2:0] MODE_GPO = 3'h3;
    localparam logic [2:0] MODE_DIV_CLK = 3'h4;
    localparam logic [1:0] SHAPE_ONE_PULSE = 2'h0;
    localparam logic [1:0] SHAPE_PULSE_TRAIN = 2'h1;
    localparam logic [1:0] SHAPE_LEVEL = 2'h2;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int PULSE_MS = 2;
    localparam int PERIOD_MS = 4;
    localparam int TIME_CNT_W = 11;
    localparam logic [TIME_CNT_W-1:0] TIMEOUT_MS [8] = '{
        11'h00b, 11'h016, 11'h02c, 11'h057, 11'h0ae, 11'h15e, 11'h2bc, 11'h4b0};
    typedef enum logic [2:0] {
        SHAPE_IDLE = 3'b001,
        SHAPE_SINGLE = 3'b010,
        SHAPE_TRAIN = 3'b100
    } shape_state_t;
endpackage

// >>> logic/clock_loss_detector.sv
`timescale 1ns/1ps
module clock_loss_detector
    import clk_mon_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic clock_level_in,
    input wire logic ms_tick_in,
    input wire logic [TIME_CNT_W-1:0] limit_ms_in,
    output logic loss_out
);
    logic prev_level;
    logic [TIME_CNT_W-1:0] ms_count;
    logic fired;
    logic clock_edge;

    assign clock_edge = clock_level_in ^ prev_level;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= clock_level_in;
        end
    end

    // Counting starts over at every monitored edge; a partial first ms is not counted
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ms_count <= '0;
            fired <= 1'b0;
            loss_out <= 1'b0;
        end else begin
            loss_out <= 1'b0;
            if (!enable_in) begin
                ms_count <= '0;
                fired <= 1'b0;
            end else if (clock_edge) begin
                ms_count <= '0;
                fired <= 1'b0;
            end else if (ms_tick_in && !fired) begin
                if (ms_count == limit_ms_in) begin
                    fired <= 1'b1;
                    loss_out <= 1'b1;
                end else begin
                    ms_count <= ms_count + 1'b1;
                end
            end
        end
    end

    AST_NO_LOSS_WHEN_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        loss_out |-> $past(enable_in))
        else $error("loss reported while detector disabled");
    AST_EDGE_RESTARTS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        enable_in && clock_edge |=> ms_count == '0 && !loss_out)
        else $error("monitored edge did not restart timeout");
endmodule

// >>> verif/alert_host_model.sv
`timescale 1ns/1ps
module alert_host_model (
    input wire logic clk_sys_in,
    input wire logic pin_in,
    input wire logic oe_n_in,
    input wire logic pull_up_in,
    input wire logic pull_down_in,
    input wire logic buffer_on_in,
    output logic level_out
);
    logic last = 1'b0;
    // A line nobody drives or pulls wanders off its last value
    always_comb begin
        if (buffer_on_in && !oe_n_in) level_out = pin_in;
        else if (pull_up_in) level_out = 1'b1;
        else if (pull_down_in) level_out = 1'b0;
        else level_out = ~last;
    end
    always_ff @(posedge clk_sys_in) last <= level_out;
endmodule

// >>> verif/clock_loss_monitor_irq_pin_test.sv
`timescale 1ns/1ps
module clock_loss_monitor_irq_pin_test;
    import clk_mon_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic div_clk = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, got;
    logic [4:0] clks = 5'h00;
    logic [4:0] run = 5'h1f;
    logic shutdown, restore, pin, oe_n, pu, pd, buf_on, level, drv;
    int n_mismatch = 0;
    int checks = 0;
    int mdl [int];
    logic [7:0] sc_mon [8] = '{0, 0, 1, 1, 1, 1, 0, 1};
    logic [7:0] sc_src [8] = '{0, 1, 0, 1, 2, 3, 0, 0};
    logic [7:0] sc_en [8] = '{1, 1, 1, 1, 1, 1, 0, 0};
    logic [7:0] sc_t [8] = '{0, 1, 0, 0, 0, 0, 0, 0};
    logic [7:0] sc_mask [8] = '{1, 0, 1, 1, 0, 1, 1, 1};
    logic [7:0] sc_shape [8] = '{0, 0, 1, 2, 0, 0, 0, 0};
    always #5 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) clks <= clks ^ run;
    clock_loss_monitor_irq_pin #(.MS_CYCLES(10), .PULSE_CYCLES(20), .PERIOD_CYCLES(40)) uut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .serial_audio_clock_in(clks[0]), .density_port_clock_in(clks[1]),
        .playback_mod_clock_in(clks[2]), .sense_mod_clock_in(clks[3]),
        .pll_clock_in(clks[4]), .density_input_divider_clock_in(div_clk),
        .shutdown_out(shutdown), .restore_defaults_out(restore), .alert_pin_out(pin),
        .alert_pin_oe_n_out(oe_n), .alert_pull_up_out(pu), .alert_pull_down_out(pd),
        .alert_buffer_on_out(buf_on));
    alert_host_model host (.clk_sys_in(clk_sys_in), .pin_in(pin), .oe_n_in(oe_n),
        .pull_up_in(pu), .pull_down_in(pd), .buffer_on_in(buf_on), .level_out(level));
    task automatic chk(string name, logic [7:0] exp, logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys_in);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_sys_in);
        wr = 1'b0;
        if (a >= 8'h21 && a <= 8'h25) mdl[a] = d;
    endtask
    task automatic rd_reg(logic [7:0] a);
        @(negedge clk_sys_in);
        rd = 1'b1;
        addr = a;
        @(negedge clk_sys_in);
        rd = 1'b0;
        got = rdata;
    endtask
    task automatic rd_chk(logic [7:0] a);
        rd_reg(a);
        chk("register", mdl.exists(a) ? mdl[a][7:0] : 8'h00, got);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        logic [7:0] ra [8] = '{8'h05, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h30};
        logic [7:0] idx;
        int lim, cnt, hi, e;
        logic rl, det, seen;
        void'($urandom(32'h0d50));
        mdl[8'h21] = 8'h03;
        mdl[8'h22] = 8'h3f;
        mdl[8'h23] = 8'h21;
        mdl[8'h24] = 8'h00;
        mdl[8'h25] = 8'h00;
        repeat (8) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        foreach (ra[i]) rd_chk(ra[i]);
        repeat (3) foreach (ra[i]) begin
            if (ra[i] != 8'h05) wr_reg(ra[i], 8'($urandom));
            if (ra[i] != 8'h05) rd_chk(ra[i]);
        end
        for (int d = 0; d < 5; d++) for (int v = 0; v < 2; v++) begin
            wr_reg(ADDR_PIN_SETUP, {d[2:0], v[0], 1'b0, MODE_GPO});
            repeat (2) @(negedge clk_sys_in);
            drv = d == 0 || ((d == 1 || d == 3) && v == 0) || ((d == 2 || d == 4) && v == 1);
            chk("oe_n", {7'h0, !drv}, {7'h0, oe_n});
            if (drv || d > 2) chk("pin level", {7'h0, v[0]}, {7'h0, level});
        end
        wr_reg(ADDR_PIN_SETUP, {5'h0, MODE_OFF});
        repeat (2) @(negedge clk_sys_in);
        chk("buffer on", 8'h00, {7'h0, buf_on});
        wr_reg(ADDR_PIN_SETUP, {5'h0, MODE_DIV_CLK});
        div_clk = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        chk("divider on pin", 8'h01, {7'h0, level});
        div_clk = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        chk("divider on pin", 8'h00, {7'h0, level});
        for (int s = 0; s < 8; s++) begin
            rl = 1'($urandom_range(0, 1));
            det = sc_en[s] && !(sc_mon[s] && sc_src[s] == 3);
            lim = (sc_t[s] == 0 ? 11 : 22) * 10;
            wr_reg(ADDR_PIN_SETUP, {5'h0, MODE_IRQ});
            wr_reg(ADDR_SHAPE_SETUP, sc_shape[s] << 6);
            wr_reg(ADDR_MASK, sc_mon[s] ? sc_mask[s] << 5 : sc_mask[s] << 2);
            wr_reg(ADDR_WINDOW_TIME, sc_mon[s] ? sc_t[s] : sc_t[s] << 3);
            wr_reg(ADDR_ERR_RELOAD_CTRL, {rl, 7'h0} | (sc_mon[s] ?
                (sc_src[s] << 2) | sc_en[s] : (sc_src[s] << 4) | (sc_en[s] << 1)));
            idx = sc_mon[s] ? 2 + (sc_src[s] > 2 ? 8'h2 : sc_src[s]) : sc_src[s];
            @(posedge clk_sys_in);
            run[idx[2:0]] = 1'b0;
            cnt = 0;
            while (shutdown !== 1'b1 && cnt < lim + 200) begin
                @(negedge clk_sys_in);
                cnt++;
            end
            chk("loss seen in time", {7'h0, det}, {7'h0, cnt >= lim && cnt <= lim + 15});
            hi = 0;
            repeat (80) begin
                @(negedge clk_sys_in);
                hi += int'(level);
            end
            e = (!det || !sc_mask[s]) ? 0 : sc_shape[s] == 0 ? 20 : sc_shape[s] == 1 ? 40 : 80;
            chk("pin high cycles", 8'h01, {7'h0, hi >= e - 2 && hi <= e + 2});
            rd_reg(ADDR_CLK_ERR_STATUS);
            chk("error status", {7'h0, det}, got);
            rd_reg(ADDR_STICKY);
            chk("sticky", det ? (sc_mon[s] ? 8'h04 : 8'h20) : 8'h00, got);
            rd_reg(ADDR_STICKY);
            chk("sticky after read", 8'h00, got);
            repeat (3) @(negedge clk_sys_in);
            chk("pin after flag read", 8'h00, {7'h0, level});
            @(posedge clk_sys_in);
            run = 5'h1f;
            wr_reg(ADDR_CLK_ERR_STATUS, 8'h00);
            seen = 1'b0;
            repeat (4) begin
                @(negedge clk_sys_in);
                seen |= restore;
            end
            chk("restore pulse", {7'h0, rl && det}, {7'h0, seen});
            chk("shutdown cleared", 8'h00, {7'h0, shutdown});
        end
        wrap_up();
    end
endmodule
